// ==== hw/hdsv_pkg.sv ====
// Purpose: Shared constants and types for the headphone offset servo control block.
// Assumes: 16-bit registers reached by a simple synchronous register port.
// Notes:   Offsets are the register addresses of the control interface.
package hdsv_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  ADDR_TRIG_ENA    = 8'h54;
   localparam logic [7:0]  ADDR_SERIES_TIME = 8'h55;
   localparam logic [7:0]  ADDR_OFFSET_VAL  = 8'h57;
   localparam logic [7:0]  ADDR_DONE_STAT   = 8'h58;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int          BIT_L_SINGLE     = 13;
   localparam int          BIT_R_SINGLE     = 12;
   localparam int          BIT_L_SERIES     = 9;
   localparam int          BIT_R_SERIES     = 8;
   localparam int          BIT_L_STARTUP    = 5;
   localparam int          BIT_R_STARTUP    = 4;
   localparam int          BIT_L_VALWR      = 3;
   localparam int          BIT_R_VALWR      = 2;
   localparam int          BIT_L_ENA        = 1;
   localparam int          BIT_R_ENA        = 0;
   localparam int          POS_COUNT_LSB    = 5;
   localparam int          POS_PERIOD_LSB   = 0;
   localparam int          POS_CORR_DONE    = 8;
   localparam int          POS_VALWR_DONE   = 4;
   localparam int          POS_START_DONE   = 0;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [6:0]  RST_SERIES_COUNT = 7'h2A;
   localparam logic [3:0]  RST_PERIOD_EXP   = 4'hA;
   localparam logic [15:0] RST_OFFSETS      = 16'h0000;

   // ----------------------------------------------------------------------
   // Timing: clock rate and unit period of periodic updates
   // ----------------------------------------------------------------------
   localparam longint      CLK_HZ           = 40_000_000;
   localparam int          PERIOD_UNIT_MS   = 256;
   localparam longint      PERIOD_UNIT_CYC  = (CLK_HZ * PERIOD_UNIT_MS) / 1000;
   localparam int          UPDATE_CYC       = 64;   // Length of one correction update.

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      HDSV_IDLE    = 3'b000,
      HDSV_SINGLE  = 3'b001,
      HDSV_SERIES  = 3'b010,
      HDSV_STARTUP = 3'b011,
      HDSV_VALWR   = 3'b100
   } hdsv_mode_t;

   typedef struct packed {
      logic       single_go;
      logic       series_go;
      logic       startup_go;
      logic       valwr_go;
      logic       enable;
      logic [6:0] series_count;
      logic [7:0] offset_value;
   } hdsv_chan_cmd_t;

   typedef struct packed {
      logic       single_busy;
      logic       series_busy;
      logic       startup_busy;
      logic       valwr_busy;
      logic       startup_done;
      logic       valwr_done;
   } hdsv_chan_stat_t;

endpackage : hdsv_pkg

// ==== hw/hdsv_channel.sv ====
// Purpose: One channel's correction sequencer for the offset servo.
// Assumes: Commands arrive as one-cycle pulses from the register block.
// Notes:   The analogue measurement is outside; each update is a fixed count.
`timescale 1ns/1ps
module hdsv_channel
   import hdsv_pkg::*;
#(
   parameter int UPD_CYC = UPDATE_CYC
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            resetn,
   // Command and periodic tick
   input  wire hdsv_chan_cmd_t  cmd,
   input  wire logic            period_tick,
   // Status and offset drive
   output hdsv_chan_stat_t      stat,
   output logic [7:0]           offset_drive
);

   // The update counter is 16 bits wide, so longer updates cannot be served.
   if (UPD_CYC < 1 || UPD_CYC > 65536) begin : g_bad_upd
      $error("UPD_CYC must lie between 1 and 65536.");
   end

   hdsv_mode_t  mode_ff;
   logic [15:0] upd_cnt_ff;
   logic [6:0]  left_ff;
   logic        upd_end;

   assign upd_end = (upd_cnt_ff == 16'(UPD_CYC - 1));

   // ----------------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------------
   // Start a correction only when enabled; a new go is ignored while busy.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_ff    <= HDSV_IDLE;
         upd_cnt_ff <= 16'h0000;
         left_ff    <= 7'h00;
      end else if (mode_ff == HDSV_IDLE) begin
         upd_cnt_ff <= 16'h0000;
         if (cmd.enable) begin
            if (cmd.startup_go) begin
               mode_ff <= HDSV_STARTUP;
            end else if (cmd.valwr_go) begin
               mode_ff <= HDSV_VALWR;
            end else if (cmd.series_go) begin
               mode_ff <= HDSV_SERIES;
               left_ff <= cmd.series_count;   // Count plus one updates.
            end else if (cmd.single_go || period_tick) begin
               mode_ff <= HDSV_SINGLE;
            end
         end
      end else if (!cmd.enable) begin
         mode_ff <= HDSV_IDLE;                // Disabling aborts the correction.
      end else if (upd_end) begin
         upd_cnt_ff <= 16'h0000;
         if (mode_ff == HDSV_SERIES && left_ff != 7'h00) begin
            left_ff <= left_ff - 7'h01;
         end else begin
            mode_ff <= HDSV_IDLE;
         end
      end else begin
         upd_cnt_ff <= upd_cnt_ff + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // Completion flags
   // ----------------------------------------------------------------------
   // Done flags stay until their own go arrives again while idle and enabled; completion wins.
   // Busy flags (in stat) and the applied offset (offset_drive) share this process with the done flags.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stat.startup_done <= 1'b0;
         stat.valwr_done   <= 1'b0;
         stat.single_busy  <= 1'b0;
         stat.series_busy  <= 1'b0;
         stat.startup_busy <= 1'b0;
         stat.valwr_busy   <= 1'b0;
         offset_drive      <= 8'h00;
      end else begin
         stat.single_busy  <= (mode_ff == HDSV_SINGLE);
         stat.series_busy  <= (mode_ff == HDSV_SERIES);
         stat.startup_busy <= (mode_ff == HDSV_STARTUP);
         stat.valwr_busy   <= (mode_ff == HDSV_VALWR);
         if (mode_ff == HDSV_STARTUP && upd_end && cmd.enable) begin
            stat.startup_done <= 1'b1;
         end else if (mode_ff == HDSV_IDLE && cmd.enable && cmd.startup_go) begin
            stat.startup_done <= 1'b0;
         end
         if (mode_ff == HDSV_VALWR && upd_end && cmd.enable) begin
            stat.valwr_done <= 1'b1;
         end else if (mode_ff == HDSV_IDLE && cmd.enable && cmd.valwr_go) begin
            stat.valwr_done <= 1'b0;
         end
         // An aborted value-write leaves the applied offset untouched.
         if (mode_ff == HDSV_VALWR && upd_end && cmd.enable) begin
            offset_drive <= cmd.offset_value;
         end
      end
   end

endmodule : hdsv_channel

// ==== hw/hdsv_servo_ctrl.sv ====
// Purpose: Register file and control for a two-channel headphone offset servo.
// Assumes: Synchronous register port, one access per cycle, read data registered.
// Notes:   Summary of operation is listed below.
//
// Summary of operation
// RULE1 - Bit 13 write starts left single correction
// RULE2 - Bit 12 write starts right single correction
// RULE3 - Single trigger bits read busy state
// RULE4 - Bits 9/8 start left/right series
// RULE5 - Series and value-write bits read value-write busy
// RULE6 - Bits 5/4 start left/right start-up
// RULE7 - Start-up bits read start-up busy
// RULE8 - Bits 3/2 select left/right value-write
// RULE9 - Bits 1/0 enable left/right servo
// RULE10 - Series count field gives value+1 updates
// RULE11 - Period field spaces periodic updates, zero off
// RULE12 - Signed offsets applied in value-write mode
// RULE13 - Bits 9:8 report value-write or start-up done
// RULE14 - Bits 5:4 report value-write completion
// RULE15 - Value-write field encodes left high, right low
// RULE16 - Bits 1:0 report start-up completion
// RULE17 - Trigger bits clear when correction finishes
`timescale 1ns/1ps
module hdsv_servo_ctrl
   import hdsv_pkg::*;
#(
   parameter longint UNIT_CYC = PERIOD_UNIT_CYC,
   parameter int     UPD_CYC  = UPDATE_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata_ff,
   // Offset values and servo enables applied to the output stages
   output logic [7:0]       left_headphone_output_ff,
   output logic [7:0]       right_headphone_output_ff,
   output logic             left_servo_enable_ff,
   output logic             right_servo_enable_ff
);

   // The unit counter is 32 bits wide, so longer units cannot be served.
   if (UNIT_CYC < 1 || UNIT_CYC > 64'h1_0000_0000) begin : g_bad_unit
      $error("UNIT_CYC must lie between 1 and 2**32.");
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   logic [6:0]      series_update_count_ff;
   logic [3:0]      periodic_update_exponent_ff;
   logic [7:0]      left_offset_value_ff;
   logic [7:0]      right_offset_value_ff;
   logic            wr_trig;
   logic            wr_timing;
   logic            wr_offset;

   assign wr_trig   = reg_wr && (reg_addr == ADDR_TRIG_ENA);
   assign wr_timing = reg_wr && (reg_addr == ADDR_SERIES_TIME);
   assign wr_offset = reg_wr && (reg_addr == ADDR_OFFSET_VAL);

   // Channel enables steer whether any correction may run.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         left_servo_enable_ff  <= 1'b0;
         right_servo_enable_ff <= 1'b0;
      end else if (wr_trig) begin
         left_servo_enable_ff  <= reg_wdata[BIT_L_ENA];                 // [RULE9]
         right_servo_enable_ff <= reg_wdata[BIT_R_ENA];                 // [RULE9]
      end
   end

   // Series count and periodic exponent.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         series_update_count_ff      <= RST_SERIES_COUNT;
         periodic_update_exponent_ff <= RST_PERIOD_EXP;
      end else if (wr_timing) begin
         series_update_count_ff      <= reg_wdata[POS_COUNT_LSB +: 7];  // [RULE10]
         periodic_update_exponent_ff <= reg_wdata[POS_PERIOD_LSB +: 4]; // [RULE11]
      end
   end

   // Signed offset values for value-write mode.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         left_offset_value_ff  <= RST_OFFSETS[15:8];
         right_offset_value_ff <= RST_OFFSETS[7:0];
      end else if (wr_offset) begin
         left_offset_value_ff  <= reg_wdata[15:8];                      // [RULE12]
         right_offset_value_ff <= reg_wdata[7:0];                       // [RULE12]
      end
   end

   // ----------------------------------------------------------------------
   // Periodic update timer
   // ----------------------------------------------------------------------
   // Unit counter makes one tick per 0.256 s; exponent counter counts units.
   logic [31:0]     unit_cnt_ff;
   logic [15:0]     unit_num_ff;
   logic            period_tick_ff;
   logic            unit_end;
   logic [15:0]     unit_target;

   assign unit_end    = (unit_cnt_ff == 32'(UNIT_CYC - 1));
   assign unit_target = 16'h0001 << periodic_update_exponent_ff;

   always_ff @(posedge clk) begin
      if (!resetn || periodic_update_exponent_ff == 4'h0) begin
         unit_cnt_ff    <= 32'h0000_0000;
         unit_num_ff    <= 16'h0000;
         period_tick_ff <= 1'b0;                                        // [RULE11]
      end else begin
         period_tick_ff <= 1'b0;
         if (unit_end) begin
            unit_cnt_ff <= 32'h0000_0000;
            if (unit_num_ff >= unit_target - 16'h0001) begin
               unit_num_ff    <= 16'h0000;
               period_tick_ff <= 1'b1;                                  // [RULE11]
            end else begin
               unit_num_ff <= unit_num_ff + 16'h0001;
            end
         end else begin
            unit_cnt_ff <= unit_cnt_ff + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Channel sequencers
   // ----------------------------------------------------------------------
   hdsv_chan_cmd_t  left_cmd;
   hdsv_chan_cmd_t  right_cmd;
   hdsv_chan_stat_t left_stat;
   hdsv_chan_stat_t right_stat;
   logic [7:0]      left_drive;
   logic [7:0]      right_drive;

   // Writes of 1 to trigger bits become one-cycle launch pulses.
   always_comb begin
      left_cmd.single_go     = wr_trig && reg_wdata[BIT_L_SINGLE];     // [RULE1]
      right_cmd.single_go    = wr_trig && reg_wdata[BIT_R_SINGLE];     // [RULE2]
      left_cmd.series_go     = wr_trig && reg_wdata[BIT_L_SERIES];     // [RULE4]
      right_cmd.series_go    = wr_trig && reg_wdata[BIT_R_SERIES];     // [RULE4]
      left_cmd.startup_go    = wr_trig && reg_wdata[BIT_L_STARTUP];    // [RULE6]
      right_cmd.startup_go   = wr_trig && reg_wdata[BIT_R_STARTUP];    // [RULE6]
      left_cmd.valwr_go      = wr_trig && reg_wdata[BIT_L_VALWR];      // [RULE8]
      right_cmd.valwr_go     = wr_trig && reg_wdata[BIT_R_VALWR];      // [RULE8]
      left_cmd.enable        = left_servo_enable_ff;                   // [RULE9]
      right_cmd.enable       = right_servo_enable_ff;                  // [RULE9]
      left_cmd.series_count  = series_update_count_ff;                 // [RULE10]
      right_cmd.series_count = series_update_count_ff;                 // [RULE10]
      left_cmd.offset_value  = left_offset_value_ff;
      right_cmd.offset_value = right_offset_value_ff;
   end

   hdsv_channel #(
      .UPD_CYC      (UPD_CYC)
   ) u_left (
      .clk          (clk),
      .resetn       (resetn),
      .cmd          (left_cmd),
      .period_tick  (period_tick_ff),
      .stat         (left_stat),
      .offset_drive (left_drive)
   );

   hdsv_channel #(
      .UPD_CYC      (UPD_CYC)
   ) u_right (
      .clk          (clk),
      .resetn       (resetn),
      .cmd          (right_cmd),
      .period_tick  (period_tick_ff),
      .stat         (right_stat),
      .offset_drive (right_drive)
   );

   // Offsets driven to the output stages after value-write completes.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         left_headphone_output_ff  <= 8'h00;
         right_headphone_output_ff <= 8'h00;
      end else begin
         left_headphone_output_ff  <= left_drive;                      // [RULE12]
         right_headphone_output_ff <= right_drive;                     // [RULE12]
      end
   end

   // ----------------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------------
   logic [15:0]     trig_view;
   logic [15:0]     done_view;
   logic [1:0]      value_write_done_flags;
   logic [1:0]      startup_done_flags;
   logic [1:0]      correction_done_flags;

   assign value_write_done_flags = {left_stat.valwr_done, right_stat.valwr_done};   // [RULE15]
   assign startup_done_flags     = {left_stat.startup_done, right_stat.startup_done}; // [RULE16]
   assign correction_done_flags  = value_write_done_flags | startup_done_flags;     // [RULE13]

   // Trigger bits read busy state and fall back to 0 on finish.
   always_comb begin
      trig_view                = 16'h0000;
      trig_view[BIT_L_SINGLE]  = left_stat.single_busy;                // [RULE3] [RULE17]
      trig_view[BIT_R_SINGLE]  = right_stat.single_busy;               // [RULE3] [RULE17]
      trig_view[BIT_L_SERIES]  = left_stat.valwr_busy || left_stat.series_busy;   // [RULE5]
      trig_view[BIT_R_SERIES]  = right_stat.valwr_busy || right_stat.series_busy; // [RULE5]
      trig_view[BIT_L_STARTUP] = left_stat.startup_busy;               // [RULE7] [RULE17]
      trig_view[BIT_R_STARTUP] = right_stat.startup_busy;              // [RULE7] [RULE17]
      trig_view[BIT_L_VALWR]   = left_stat.valwr_busy;                 // [RULE5] [RULE17]
      trig_view[BIT_R_VALWR]   = right_stat.valwr_busy;                // [RULE5] [RULE17]
      trig_view[BIT_L_ENA]     = left_servo_enable_ff;
      trig_view[BIT_R_ENA]     = right_servo_enable_ff;
   end

   // Completion status word.
   always_comb begin
      done_view                           = 16'h0000;
      done_view[POS_CORR_DONE +: 2]       = correction_done_flags;     // [RULE13]
      done_view[POS_VALWR_DONE +: 2]      = value_write_done_flags;    // [RULE14]
      done_view[POS_START_DONE +: 2]      = startup_done_flags;        // [RULE16]
   end

   // Registered read data; unmapped addresses read zero.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_TRIG_ENA:    reg_rdata_ff <= trig_view;
            ADDR_SERIES_TIME: reg_rdata_ff <= {4'h0, series_update_count_ff, 1'b0,
                                               periodic_update_exponent_ff};
            ADDR_OFFSET_VAL:  reg_rdata_ff <= {left_offset_value_ff, right_offset_value_ff};
            ADDR_DONE_STAT:   reg_rdata_ff <= done_view;
            default:          reg_rdata_ff <= 16'h0000;
         endcase
      end
   end

endmodule : hdsv_servo_ctrl

// ==== test/hdsv_servo_checker.sv ====
// Purpose: Concurrent checks on the ports of the offset servo control block.
// Assumes: Read data is registered on the edge that takes the read strobe.
// Notes:   Shadow copies of the set-up registers follow the host writes.
`timescale 1ns/1ps
module hdsv_servo_checker
   import hdsv_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_ff,
   // Output stages
   input wire logic [7:0]  left_headphone_output_ff,
   input wire logic [7:0]  right_headphone_output_ff,
   input wire logic        left_servo_enable_ff,
   input wire logic        right_servo_enable_ff
);
   logic [15:0] cfg_ff;
   logic [15:0] ofs_ff;

   // ----------------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------------
   // Keeps what the host last wrote, so reads and outputs can be judged.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_ff <= {4'h0, RST_SERIES_COUNT, 1'b0, RST_PERIOD_EXP};
         ofs_ff <= RST_OFFSETS;
      end else if (reg_wr && reg_addr == ADDR_SERIES_TIME) begin
         cfg_ff <= reg_wdata & 16'h0FEF;
      end else if (reg_wr && reg_addr == ADDR_OFFSET_VAL) begin
         ofs_ff <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   // All checks share one clock and the block reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   left_ena_load_a: assert property (reg_wr && reg_addr == ADDR_TRIG_ENA
      |=> left_servo_enable_ff == $past(reg_wdata[1])) else $error("Left enable wrong.");
   right_ena_load_a: assert property (reg_wr && reg_addr == ADDR_TRIG_ENA
      |=> right_servo_enable_ff == $past(reg_wdata[0])) else $error("Right enable wrong.");
   ena_readback_a: assert property (reg_rd && reg_addr == ADDR_TRIG_ENA
      |=> reg_rdata_ff[1:0] == $past({left_servo_enable_ff, right_servo_enable_ff}))
      else $error("Enable readback wrong.");
   valwr_busy_a: assert property (reg_rd && reg_addr == ADDR_TRIG_ENA
      |=> (!reg_rdata_ff[3] || reg_rdata_ff[9]) && (!reg_rdata_ff[2] || reg_rdata_ff[8]))
      else $error("Value-write busy not mirrored.");
   cfg_read_a: assert property (reg_rd && reg_addr == ADDR_SERIES_TIME
      |=> reg_rdata_ff == $past(cfg_ff)) else $error("Series timing readback wrong.");
   ofs_read_a: assert property (reg_rd && reg_addr == ADDR_OFFSET_VAL
      |=> reg_rdata_ff == $past(ofs_ff)) else $error("Offset readback wrong.");
   done_merge_a: assert property (reg_rd && reg_addr == ADDR_DONE_STAT
      |=> reg_rdata_ff[9:8] == (reg_rdata_ff[5:4] | reg_rdata_ff[1:0])
      && (reg_rdata_ff & 16'hFCCC) == 16'h0000) else $error("Done flags inconsistent.");
   left_out_value_a: assert property ($changed(left_headphone_output_ff)
      |-> left_headphone_output_ff == ofs_ff[15:8]) else $error("Left offset wrong.");
   right_out_value_a: assert property ($changed(right_headphone_output_ff)
      |-> right_headphone_output_ff == ofs_ff[7:0]) else $error("Right offset wrong.");
   left_off_hold_a: assert property (!left_servo_enable_ff ##1 !left_servo_enable_ff
      |=> $stable(left_headphone_output_ff)) else $error("Disabled left output moved.");
endmodule : hdsv_servo_checker

bind hdsv_servo_ctrl hdsv_servo_checker chk_u (
   .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
   .left_headphone_output_ff(left_headphone_output_ff),
   .right_headphone_output_ff(right_headphone_output_ff),
   .left_servo_enable_ff(left_servo_enable_ff), .right_servo_enable_ff(right_servo_enable_ff));

// ==== test/hdsv_servo_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the offset servo control registers.
// Assumes: Short update and period units keep the run brief.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/1ps
module hdsv_servo_ctrl_tb_top
   import hdsv_pkg::*;
;
   localparam longint UNIT = 10;
   localparam int     UPD  = 4;

   logic        clk;
   logic        resetn;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata_ff;
   logic [7:0]  lout;
   logic [7:0]  rout;
   logic        len;
   logic        ren;
   int          n_errors;
   int          samples_checked;
   logic [15:0] trig_tab [8] = '{16'h1000, 16'h2000, 16'h0100, 16'h0200,
                                 16'h0010, 16'h0020, 16'h0008, 16'h0004};
   logic [15:0] busy_tab [8] = '{16'h1000, 16'h2000, 16'h0100, 16'h0200,
                                 16'h0010, 16'h0020, 16'h0208, 16'h0104};
   logic [15:0] stat_tab [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                 16'h0101, 16'h0303, 16'h0323, 16'h0333};

   // ----------------------------------------------------------------------
   // Design and clock
   // ----------------------------------------------------------------------
   hdsv_servo_ctrl #(.UNIT_CYC(UNIT), .UPD_CYC(UPD)) dut_u (
      .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .left_headphone_output_ff(lout), .right_headphone_output_ff(rout),
      .left_servo_enable_ff(len), .right_servo_enable_ff(ren));

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // Access and check tasks
   // ----------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // Compares one value with its expectation.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   // One-cycle read strobe; data is taken once it has settled.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = reg_rdata_ff;
   endtask : rd

   // Polls the trigger register until the masked busy bits fall, with a bound.
   task automatic wait_clear(input logic [15:0] mask);
      logic [15:0] v;
      int          i;
      v = mask;
      for (i = 0; i < 100 && (v & mask) !== 16'h0000; i++) rd(ADDR_TRIG_ENA, v);
      if ((v & mask) !== 16'h0000) begin
         n_errors++;
         $display("ERROR busy wait expected 0000 seen %h", v & mask);
         report_and_stop();
      end
   endtask : wait_clear

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   // Reset checks, every trigger in turn, series length and periodic timer.
   initial begin
      logic [15:0] v;
      int          k;
      n_errors        = 0;
      samples_checked = 0;
      resetn          = 1'b0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      reg_addr        = 8'h00;
      reg_wdata       = 16'h0000;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      rd(ADDR_SERIES_TIME, v);
      check("series timing reset", v, 16'h054A);
      rd(ADDR_OFFSET_VAL, v);
      check("offsets reset", v, 16'h0000);
      rd(ADDR_DONE_STAT, v);
      check("done flags reset", v, 16'h0000);
      wr(8'h56, 16'hFFFF);
      rd(8'h56, v);
      check("unmapped read", v, 16'h0000);
      wr(ADDR_SERIES_TIME, 16'h0060);
      rd(ADDR_SERIES_TIME, v);
      check("series timing", v, 16'h0060);
      wr(ADDR_OFFSET_VAL, 16'h807F);
      rd(ADDR_OFFSET_VAL, v);
      check("offsets", v, 16'h807F);
      wr(ADDR_TRIG_ENA, 16'h0020);
      rd(ADDR_TRIG_ENA, v);
      check("trigger while disabled", v, 16'h0000);
      wr(ADDR_TRIG_ENA, 16'h0003);
      for (k = 0; k < 8; k++) begin
         wr(ADDR_TRIG_ENA, trig_tab[k] | 16'h0003);
         rd(ADDR_TRIG_ENA, v);
         check("busy readback", v, busy_tab[k] | 16'h0003);
         wait_clear(16'h333C);
         rd(ADDR_TRIG_ENA, v);
         check("trigger cleared", v, 16'h0003);
         rd(ADDR_DONE_STAT, v);
         check("done flags", v, stat_tab[k]);
      end
      check("left offset", {8'h00, lout}, 16'h0080);
      check("right offset", {8'h00, rout}, 16'h007F);
      wr(ADDR_TRIG_ENA, 16'h0023);
      wr(ADDR_TRIG_ENA, 16'h0001);
      repeat (8) @(negedge clk);
      check("enable pins", {14'h0000, len, ren}, 16'h0001);
      rd(ADDR_TRIG_ENA, v);
      check("aborted start-up", v, 16'h0001);
      rd(ADDR_DONE_STAT, v);
      check("aborted done flags", v, 16'h0331);
      wr(ADDR_TRIG_ENA, 16'h0003);
      wr(ADDR_TRIG_ENA, 16'h0203);
      repeat (10) @(negedge clk);
      rd(ADDR_TRIG_ENA, v);
      check("four-update series busy", v, 16'h0203);
      wait_clear(16'h333C);
      wr(ADDR_SERIES_TIME, 16'h0000);
      wr(ADDR_TRIG_ENA, 16'h0203);
      repeat (10) @(negedge clk);
      rd(ADDR_TRIG_ENA, v);
      check("one-update series done", v, 16'h0003);
      wr(ADDR_SERIES_TIME, 16'h0001);
      v = 16'h0000;
      for (k = 0; k < 50 && (v & 16'h3000) === 16'h0000; k++) rd(ADDR_TRIG_ENA, v);
      check("periodic single", {15'h0000, (v & 16'h3000) != 16'h0000}, 16'h0001);
      wr(ADDR_SERIES_TIME, 16'h0000);
      wait_clear(16'h333C);
      repeat (60) @(negedge clk);
      rd(ADDR_TRIG_ENA, v);
      check("periodic off", v, 16'h0003);
      report_and_stop();
   end
endmodule : hdsv_servo_ctrl_tb_top
